// file: core/ret_timer.v
// reload event timer with output pin, apb register slave
`timescale 1ns/1ps
// Contract
// - 8-bit counter counts each selected input pulse; pulse at ff overflows.
// - reload mode reloads the two held write digits on overflow.
// - free-running mode wraps to 00 on overflow and keeps counting.
// - overflow sets flag bit 0 at index 002; cleared by writing 0 to it or reset.
// - event source counts falling edges of the event pin.
// - output mode register at 013 is read/write, 2-bit mode field.
// - reset drives output low and clears both mode registers.
// - toggle mode inverts the output on each overflow.
// - force-low mode drives output low on overflow; use while high.
// - force-high mode drives output high on overflow; use while low.
// - counter mode bit 3 selects free-running (0) or reload (1).
// - counter mode bits 2..0 select prescaler period or event pin.
// - counter mode write takes effect from the second cycle after it.
// - write digits are write-only; reset clears the lower digit.
// - reads return counter digits, writes load write digits, same index.
// - upper digit write loads counter from both digits; lower alone holds.
// - upper read returns upper count and latches lower for later read.
`include "ret_defines.vh"

module ret_timer (
    input  wire        clk_i,
    input  wire        rstn_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    input  wire        event_input_pin_i,
    output reg         timer_output_pin_o,
    output wire        timer_output_pin_oe_o,
    output wire        overflow_irq_flag_o,
    output wire [3:0]  pin_function_select_o,
    output reg  [7:0]  count_value_o
);

    localparam ST_IDLE = 1'b0;
    localparam ST_WAIT = 1'b1;

    reg  [10:0] prescaler;
    reg  [7:0]  count;
    reg  [3:0]  counter_mode_select;
    reg  [3:0]  mode_pending;
    reg         mode_state;
    reg  [1:0]  output_mode_select;
    reg  [3:0]  reload_value_low;
    reg  [3:0]  reload_value_high;
    reg  [3:0]  pin_function_select;
    reg  [3:0]  count_read_low;
    reg         overflow_irq_flag;
    reg         event_sync1;
    reg         event_sync2;
    reg         event_prev;

    wire [9:0]  idx;
    wire        setup_rd;
    wire        access;
    wire        wr_en;
    wire        mapped;
    wire        wr_cmode;
    wire        wr_low;
    wire        wr_high;
    wire        wr_omode;
    wire        wr_pfunc;
    wire        wr_flag;
    wire        event_fall;
    wire        presc_tick;
    wire        in_pulse;
    wire        overflow;
    wire [7:0]  reload_word;
    reg  [7:0]  next_count;
    reg         next_out;
    reg  [31:0] next_rdata;

    // all-ones mask on the prescaler low bits that marks one period
    function [10:0] div_mask;
        input [2:0] sel;
        begin
            case (sel)
                `RET_SEL_2048: div_mask = `RET_DIV_2048;
                `RET_SEL_512:  div_mask = `RET_DIV_512;
                `RET_SEL_128:  div_mask = `RET_DIV_128;
                `RET_SEL_32:   div_mask = `RET_DIV_32;
                `RET_SEL_8:    div_mask = `RET_DIV_8;
                `RET_SEL_4:    div_mask = `RET_DIV_4;
                `RET_SEL_2:    div_mask = `RET_DIV_2;
                default:       div_mask = `RET_DIV_NONE;
            endcase
        end
    endfunction

    function hit;
        input [9:0] a;
        input [9:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    // bus decode: zero wait states, unmapped index answers with an error
    assign idx      = paddr_i[11:2];
    assign access   = psel_i & penable_i;
    assign setup_rd = psel_i & ~penable_i & ~pwrite_i;
    assign mapped   = hit(idx, `RET_IDX_FLAG) |
                      hit(idx, `RET_IDX_CMODE) |
                      hit(idx, `RET_IDX_DIG_LOW) |
                      hit(idx, `RET_IDX_DIG_HIGH) |
                      hit(idx, `RET_IDX_OMODE) |
                      hit(idx, `RET_IDX_PFUNC);
    assign pready_o  = 1'b1;
    assign pslverr_o = access & ~mapped;
    assign wr_en     = access & pwrite_i & mapped;
    assign wr_flag   = wr_en & hit(idx, `RET_IDX_FLAG);
    assign wr_cmode  = wr_en & hit(idx, `RET_IDX_CMODE);
    assign wr_low    = wr_en & hit(idx, `RET_IDX_DIG_LOW);
    assign wr_high   = wr_en & hit(idx, `RET_IDX_DIG_HIGH);
    assign wr_omode  = wr_en & hit(idx, `RET_IDX_OMODE);
    assign wr_pfunc  = wr_en & hit(idx, `RET_IDX_PFUNC);

    // the pin function is only stored; the pin mux sits outside
    assign pin_function_select_o = pin_function_select;
    assign overflow_irq_flag_o   = overflow_irq_flag;
    assign timer_output_pin_oe_o = (output_mode_select != `RET_OUT_PORT);

    // read data is captured in the setup cycle so it comes from a flop
    always @* begin
        next_rdata = 32'h0000_0000;
        if (hit(idx, `RET_IDX_FLAG)) begin
            next_rdata[`RET_FLAG_BIT] = overflow_irq_flag;
        end else if (hit(idx, `RET_IDX_DIG_LOW)) begin
            next_rdata[3:0] = count_read_low;
        end else if (hit(idx, `RET_IDX_DIG_HIGH)) begin
            next_rdata[3:0] = count[7:4];
        end else if (hit(idx, `RET_IDX_OMODE)) begin
            next_rdata[1:0] = output_mode_select;
        end else begin
            next_rdata = 32'h0000_0000;
        end
    end

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata_o <= next_rdata;
        end
    end

    // lower count is frozen when the upper digit is read
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_read_low <= 4'h0;
        end else if (setup_rd & hit(idx, `RET_IDX_DIG_HIGH)) begin
            count_read_low <= count[3:0];
        end
    end

    // write digits; upper digit has no documented reset, cleared anyway
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reload_value_low  <= `RET_RLOW_RST;
            reload_value_high <= `RET_RHIGH_RST;
        end else begin
            if (wr_low) begin
                reload_value_low <= pwdata_i[3:0];
            end
            if (wr_high) begin
                reload_value_high <= pwdata_i[3:0];
            end
        end
    end

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            output_mode_select  <= `RET_OMODE_RST;
            pin_function_select <= `RET_PFUNC_RST;
        end else begin
            if (wr_omode) begin
                output_mode_select <= pwdata_i[1:0];
            end
            if (wr_pfunc) begin
                pin_function_select <= pwdata_i[3:0];
            end
        end
    end

    // mode writes pass through one pending stage before use
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            counter_mode_select <= `RET_CMODE_RST;
            mode_pending        <= `RET_CMODE_RST;
            mode_state          <= ST_IDLE;
        end else begin
            case (mode_state)
                ST_IDLE: begin
                    if (wr_cmode) begin
                        mode_pending <= pwdata_i[3:0];
                        mode_state   <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    counter_mode_select <= mode_pending;
                    if (wr_cmode) begin
                        mode_pending <= pwdata_i[3:0];
                    end else begin
                        mode_state <= ST_IDLE;
                    end
                end
                default: begin
                    mode_state <= ST_IDLE;
                end
            endcase
        end
    end

    // free-running prescaler of instruction cycles
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prescaler <= 11'h000;
        end else begin
            prescaler <= prescaler + 11'h001;
        end
    end

    // event pin: two-flop synchroniser, then edge detect on later stages
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            event_sync1 <= 1'b1;
            event_sync2 <= 1'b1;
            event_prev  <= 1'b1;
        end else begin
            event_sync1 <= event_input_pin_i;
            event_sync2 <= event_sync1;
            event_prev  <= event_sync2;
        end
    end

    assign event_fall = event_prev & ~event_sync2;

    assign presc_tick = ((prescaler & div_mask(counter_mode_select[2:0]))
                        == div_mask(counter_mode_select[2:0]));

    assign in_pulse = (counter_mode_select[2:0] == `RET_SEL_EVENT) ?
                      event_fall : presc_tick;

    assign overflow    = in_pulse & (count == `RET_COUNT_MAX);
    assign reload_word = {reload_value_high, reload_value_low};

    // a software load wins over a coincident input pulse
    always @* begin
        next_count = count;
        if (wr_high) begin
            next_count = {pwdata_i[3:0], reload_value_low};
        end else if (overflow) begin
            if (counter_mode_select[`RET_RELOAD_BIT]) begin
                next_count = reload_word;
            end else begin
                next_count = `RET_COUNT_ZERO;
            end
        end else if (in_pulse) begin
            next_count = count + 8'h01;
        end
    end

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count         <= `RET_COUNT_RST;
            count_value_o <= `RET_COUNT_RST;
        end else begin
            count         <= next_count;
            count_value_o <= next_count;
        end
    end

    // set beats a clear that lands in the same cycle
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            overflow_irq_flag <= 1'b0;
        end else if (overflow) begin
            overflow_irq_flag <= 1'b1;
        end else if (wr_flag & ~pwdata_i[`RET_FLAG_BIT]) begin
            overflow_irq_flag <= 1'b0;
        end
    end

    // force modes do not check the level; software picks them safely
    always @* begin
        next_out = timer_output_pin_o;
        if (overflow) begin
            case (output_mode_select)
                `RET_OUT_TOGGLE: next_out = ~timer_output_pin_o;
                `RET_OUT_LOW:    next_out = 1'b0;
                `RET_OUT_HIGH:   next_out = 1'b1;
                default:         next_out = timer_output_pin_o;
            endcase
        end
    end

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            timer_output_pin_o <= 1'b0;
        end else begin
            timer_output_pin_o <= next_out;
        end
    end

endmodule

// file: common/ret_defines.vh
// register indices, fields, reset values and timing counts of the timer
`ifndef RET_DEFINES_VH
`define RET_DEFINES_VH

`define RET_ADDR_W        12
`define RET_IDX_W         10
`define RET_IDX_FLAG      10'h002
`define RET_IDX_CMODE     10'h009
`define RET_IDX_DIG_LOW   10'h00a
`define RET_IDX_DIG_HIGH  10'h00b
`define RET_IDX_OMODE     10'h013
`define RET_IDX_PFUNC     10'h025

`define RET_FLAG_BIT      0
`define RET_RELOAD_BIT    3

`define RET_CMODE_RST     4'h0
`define RET_OMODE_RST     2'h0
`define RET_RLOW_RST      4'h0
`define RET_RHIGH_RST     4'h0
`define RET_PFUNC_RST     4'h0
`define RET_COUNT_RST     8'h00
`define RET_COUNT_MAX     8'hff
`define RET_COUNT_ZERO    8'h00

`define RET_SEL_2048      3'h0
`define RET_SEL_512       3'h1
`define RET_SEL_128       3'h2
`define RET_SEL_32        3'h3
`define RET_SEL_8         3'h4
`define RET_SEL_4         3'h5
`define RET_SEL_2         3'h6
`define RET_SEL_EVENT     3'h7

`define RET_DIV_2048      11'h7ff
`define RET_DIV_512       11'h1ff
`define RET_DIV_128       11'h07f
`define RET_DIV_32        11'h01f
`define RET_DIV_8         11'h007
`define RET_DIV_4         11'h003
`define RET_DIV_2         11'h001
`define RET_DIV_NONE      11'h000

`define RET_OUT_PORT      2'h0
`define RET_OUT_TOGGLE    2'h1
`define RET_OUT_LOW       2'h2
`define RET_OUT_HIGH      2'h3

`endif

// file: tb/ret_asserts.sv
// concurrent checks on the timer ports
`timescale 1ns/1ps
module ret_asserts (
    input wire        clk_i,
    input wire        rstn_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire        pready_o,
    input wire        pslverr_o,
    input wire        timer_output_pin_o,
    input wire        timer_output_pin_oe_o,
    input wire        overflow_irq_flag_o,
    input wire [3:0]  pin_function_select_o,
    input wire [7:0]  count_value_o
);
    wire       acc = psel_i & penable_i;
    wire       wr = acc & pwrite_i;
    wire [9:0] ix = paddr_i[11:2];
    wire       map = ix == 10'h002 || ix == 10'h009 || ix == 10'h00a ||
                     ix == 10'h00b || ix == 10'h013 || ix == 10'h025;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    chk_ready_no_wait: assert property (
        acc |-> pready_o) else $error("ready low");
    chk_err_unmapped: assert property (
        acc |-> pslverr_o == !map) else $error("bad error flag");
    chk_unmapped_zero: assert property (
        acc && !pwrite_i && !map |-> prdata_o == 32'h0)
        else $error("unmapped read data");
    // a write may load the count, so only quiet cycles are judged
    chk_count_step: assert property (
        !wr && count_value_o != 8'hff ##1 $changed(count_value_o)
        |-> count_value_o == $past(count_value_o) + 8'h01)
        else $error("count skipped");
    chk_flag_on_ovf: assert property (
        !wr && count_value_o == 8'hff ##1 count_value_o != 8'hff
        |-> overflow_irq_flag_o) else $error("flag not set");
    chk_out_on_ovf: assert property (
        $changed(timer_output_pin_o) |-> $past(count_value_o) == 8'hff)
        else $error("output moved without overflow");
    chk_flag_sticky: assert property (
        $fell(overflow_irq_flag_o)
        |-> $past(wr && ix == 10'h002 && !pwdata_i[0]))
        else $error("flag cleared by itself");
    chk_upper_load: assert property (
        wr && ix == 10'h00b |=> count_value_o[7:4] == $past(pwdata_i[3:0]))
        else $error("upper load lost");
    chk_pin_func: assert property (
        wr && ix == 10'h025 |=> pin_function_select_o == $past(pwdata_i[3:0]))
        else $error("pin function lost");
    chk_reset_idle: assert property (disable iff (1'b0)
        !rstn_i |-> !timer_output_pin_o && !timer_output_pin_oe_o &&
        !overflow_irq_flag_o && count_value_o == 8'h00)
        else $error("reset state wrong");
    cover property ($rose(overflow_irq_flag_o));
    cover property (wr && ix == 10'h00b);
    cover property (acc && pslverr_o);
endmodule
bind ret_timer ret_asserts i_ret_asserts (.clk_i, .rstn_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .timer_output_pin_o, .timer_output_pin_oe_o,
    .overflow_irq_flag_o, .pin_function_select_o, .count_value_o);

// file: tb/ret_evt_src.sv
// event pin source: one falling edge per request
`timescale 1ns/1ps
module ret_evt_src (
    input  wire clk_i,
    input  wire req_i,
    output reg  event_pin_o
);
    reg [1:0] low_cnt;
    initial begin
        event_pin_o = 1'b1;
        low_cnt = 2'h0;
    end
    // low level held two cycles so the synchroniser sees it
    always @(posedge clk_i) begin
        if (req_i) begin
            event_pin_o <= 1'b0;
            low_cnt <= 2'h2;
        end else if (low_cnt != 2'h0) begin
            low_cnt <= low_cnt - 2'h1;
            if (low_cnt == 2'h1)
                event_pin_o <= 1'b1;
        end
    end
endmodule

// file: tb/tb_ret_timer.sv
// self-checking bench for the reload event timer
`timescale 1ns/1ps
module tb_ret_timer;
    reg         clk_i, rstn_i, psel_i, penable_i, pwrite_i, ev_req, err;
    reg  [11:0] paddr_i;
    reg  [31:0] pwdata_i, rd;
    wire [31:0] prdata_o;
    wire        pready_o, pslverr_o, evt, tout, toe, flag;
    wire [3:0]  pfunc;
    wire [7:0]  cnt;
    integer     fails, comparisons, i, p, c0;
    ret_timer i_ret_timer (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .event_input_pin_i(evt),
        .timer_output_pin_o(tout), .timer_output_pin_oe_o(toe),
        .overflow_irq_flag_o(flag), .pin_function_select_o(pfunc),
        .count_value_o(cnt));
    ret_evt_src i_ret_evt_src (.clk_i(clk_i), .req_i(ev_req),
        .event_pin_o(evt));
    task results;
        begin
            if (fails == 0 && comparisons > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] exp, input [31:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                $display("CHECK FAILED %0s exp %h got %h", nm, exp, got);
                fails = fails + 1;
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk_i);
            psel_i <= 1'b1;
            pwrite_i <= w;
            paddr_i <= a;
            pwdata_i <= d;
            @(posedge clk_i);
            penable_i <= 1'b1;
            @(posedge clk_i);
            for (n = 0; n < 16 && pready_o !== 1'b1; n = n + 1)
                @(posedge clk_i);
            if (n == 16) begin
                fails = fails + 1;
                results;
            end
            rd = prdata_o;
            err = pslverr_o;
            psel_i <= 1'b0;
            penable_i <= 1'b0;
            @(negedge clk_i);
        end
    endtask
    task rdc(input string nm, input [11:0] a, input [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            chk(nm, exp, rd);
        end
    endtask
    task ev(input integer n);
        begin
            repeat (n) begin
                @(posedge clk_i);
                ev_req <= 1'b1;
                @(posedge clk_i);
                ev_req <= 1'b0;
                repeat (4) @(posedge clk_i);
            end
            repeat (3) @(negedge clk_i);
        end
    endtask
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        fails = fails + 1;
        results;
    end
    initial begin
        // nba at time zero so every async reset process sees the edge
        {rstn_i, psel_i, penable_i, pwrite_i, ev_req} <= 5'h0;
        paddr_i <= 12'h0;
        pwdata_i <= 32'h0;
        fails = 0;
        comparisons = 0;
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(negedge clk_i);
        chk("count", 8'h00, cnt);
        chk("out", 1'b0, tout);
        chk("oe", 1'b0, toe);
        chk("flag", 1'b0, flag);
        rdc("omode", 12'h04c, 32'h0);
        apb(1'b1, 12'h094, 32'h5);
        chk("pfunc", 4'h5, pfunc);
        apb(1'b1, 12'h024, 32'h7);
        repeat (2) @(posedge clk_i);
        apb(1'b1, 12'h02c, 32'h3);
        chk("count", 8'h30, cnt);
        apb(1'b1, 12'h028, 32'hc);
        chk("count", 8'h30, cnt);
        ev(5);
        chk("count", 8'h35, cnt);
        rdc("rd_hi", 12'h02c, 32'h3);
        ev(2);
        rdc("rd_lo", 12'h028, 32'h5);
        rdc("rd_hi", 12'h02c, 32'h3);
        rdc("rd_lo", 12'h028, 32'h7);
        for (i = 0; i < 4; i = i + 1) begin
            apb(1'b1, 12'h04c, i);
            rdc("omode", 12'h04c, i);
            chk("oe", i != 0, toe);
        end
        apb(1'b1, 12'h04c, 32'h1);
        apb(1'b1, 12'h02c, 32'hf);
        ev(4);
        chk("count", 8'h00, cnt);
        chk("flag", 1'b1, flag);
        chk("out", 1'b1, tout);
        ev(1);
        chk("count", 8'h01, cnt);
        apb(1'b1, 12'h008, 32'h1);
        chk("flag", 1'b1, flag);
        apb(1'b1, 12'h008, 32'h0);
        chk("flag", 1'b0, flag);
        // reload from f0 keeps each force mode run to sixteen pulses
        apb(1'b1, 12'h024, 32'hf);
        repeat (2) @(posedge clk_i);
        apb(1'b1, 12'h028, 32'h0);
        apb(1'b1, 12'h02c, 32'hf);
        for (i = 2; i < 4; i = i + 1) begin
            apb(1'b1, 12'h04c, i);
            apb(1'b1, 12'h008, 32'h0);
            ev(16);
            chk("count", 8'hf0, cnt);
            chk("flag", 1'b1, flag);
            chk("out", i == 3, tout);
        end
        apb(1'b1, 12'h04c, 32'h0);
        // no events arrive, so only an early prescaler tick could move it
        c0 = cnt;
        apb(1'b1, 12'h024, 32'h6);
        @(negedge clk_i);
        chk("mode_delay", c0, cnt);
        for (i = 0; i < 7; i = i + 1) begin
            p = (i < 4) ? 2048 >> (2 * i) : 8 >> (i - 4);
            apb(1'b1, 12'h024, i);
            repeat (3) @(negedge clk_i);
            c0 = cnt;
            repeat (4 * p) @(negedge clk_i);
            chk("rate", (c0 + 4) & 8'hff, cnt);
        end
        apb(1'b1, 12'h0fc, 32'h1);
        chk("slverr", 1'b1, err);
        rdc("unmapped", 12'h0fc, 32'h0);
        results;
    end
endmodule
